// ---- verilog/arf_pkg.sv ----
// constants for the ascii reply framer with reception timeout
package arf_pkg;
	// ************************************************************
	// character codes
	// ************************************************************
	localparam logic [7:0] CH_STX = 8'h02;
	localparam logic [7:0] CH_ACK = 8'h06;
	localparam logic [7:0] CH_CR = 8'h0D;
	localparam logic [7:0] CH_NAK = 8'h15;
	localparam logic [7:0] CH_ZERO = 8'h30;
	localparam logic [7:0] CH_NINE = 8'h39;
	localparam logic [7:0] CH_UA = 8'h41;
	localparam logic [7:0] CH_UF = 8'h46;
	localparam logic [7:0] CH_UH = 8'h48;
	localparam logic [7:0] CH_UP = 8'h50;
	localparam logic [7:0] CH_LB = 8'h62;
	localparam logic [7:0] CH_HEX_AF = 8'h37;  // 'A' minus ten
	localparam logic [7:0] LOOP_PATTERN = 8'h55;
	// ************************************************************
	// negative reply error codes
	// ************************************************************
	localparam logic [7:0] ERR_NONE = 8'h00;
	localparam logic [7:0] ERR_PARITY = 8'h01;
	localparam logic [7:0] ERR_CHECKSUM = 8'h02;
	localparam logic [7:0] ERR_FRAMING = 8'h03;
	localparam logic [7:0] ERR_OVERRUN = 8'h04;
	localparam logic [7:0] ERR_PROTOCOL = 8'h05;
	localparam logic [7:0] ERR_ASCII = 8'h06;
	localparam logic [7:0] ERR_BUF_OVR = 8'h07;
	localparam logic [7:0] ERR_TIMEOUT = 8'h08;
	localparam logic [7:0] ERR_UNK_CMD = 8'h11;
	localparam logic [7:0] ERR_EXEC_DIS = 8'h13;
	localparam logic [7:0] ERR_PARAM = 8'h16;
	// ************************************************************
	// register map (byte offsets) and fields
	// ************************************************************
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_TIMEOUT = 8'h04;
	localparam logic [7:0] OFF_WAIT = 8'h08;
	localparam logic [7:0] OFF_CHARTIME = 8'h0C;
	localparam logic [7:0] OFF_STATUS = 8'h10;
	localparam logic [7:0] OFF_QUERY = 8'h14;
	localparam logic [7:0] OFF_REPLY = 8'h18;
	localparam int CTRL_ACT_LSB = 8;
	localparam int CTRL_SPD_LSB = 16;
	localparam int REPLY_NAK_BIT = 8;
	localparam int ST_TIMEOUT_BIT = 2;
	localparam logic [5:0] RST_STATION = 6'h01;
	localparam logic [2:0] RST_ERR_ACTION = 3'h2;
	localparam logic [7:0] RST_SPEED_SEL = 8'h04;
	localparam logic [7:0] SPEED_LOOPBACK = 8'h02;
	localparam logic [2:0] ACT_TRIP = 3'h0;
	localparam logic [2:0] ACT_DECEL_TRIP = 3'h1;
	localparam logic [2:0] ACT_IGNORE = 3'h2;
	localparam logic [2:0] ACT_COAST = 3'h3;
	localparam logic [2:0] ACT_DECEL = 3'h4;
	// ************************************************************
	// timing
	// ************************************************************
	localparam int CLK_PERIOD_PS = 5000;
	localparam int TICK_PS = 100000000;  // 0.1 ms wait-time step
	localparam int TICK_CYC = TICK_PS / CLK_PERIOD_PS;
	localparam int TIMEOUT_TICKS = 100;  // 0.01 s step in ticks
	localparam int CHAR_CYC_DEF = 208334;  // one 10-bit char at 9600 Bd
	localparam int MAX_QUERY = 16;  // bytes held after start-of-text
endpackage

// ---- verilog/arf_top.sv ----
// ascii reply framer with reception timeout and ahb-lite registers
//
// Design decisions made here: the register offsets and register access over AHB-Lite.
`timescale 1ns/10ps
module arf_top
	import arf_pkg::*;
#(
	parameter int TICK_CYCLES = TICK_CYC,
	parameter int CHAR_CYCLES = CHAR_CYC_DEF
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic [7:0] speed_select_strap,
	input wire logic rx_valid,
	input wire logic [7:0] rx_data,
	input wire logic rx_parity_err,
	input wire logic rx_framing_err,
	input wire logic rx_overrun_err,
	output logic tx_valid,
	output logic [7:0] tx_data,
	input wire logic tx_ready,
	output logic comm_error_trip,
	output logic stop_decel_req,
	output logic stop_coast_req
);
	typedef enum logic [5:0] {
		ARF_IDLE = 6'b000001,
		ARF_RECV = 6'b000010,
		ARF_DECIDE = 6'b000100,
		ARF_GAP = 6'b001000,
		ARF_SEND = 6'b010000,
		ARF_LOOP = 6'b100000
	} arf_state_t;

	// ************************************************************
	// functions
	// ************************************************************
	// nibble to ascii hex digit
	function automatic logic [7:0] hex2asc(input logic [3:0] n);
		hex2asc = (n < 4'hA) ? CH_ZERO + {4'h0, n} : CH_HEX_AF + {4'h0, n};
	endfunction

	// ascii hex digit to {valid, nibble}
	function automatic logic [4:0] asc2hex(input logic [7:0] c);
		logic [7:0] t;
		t = 8'h00;
		if (c >= CH_ZERO && c <= CH_NINE) begin
			t = c - CH_ZERO;
			asc2hex = {1'b1, t[3:0]};
		end else if (c >= CH_UA && c <= CH_UF) begin
			t = c - CH_HEX_AF;
			asc2hex = {1'b1, t[3:0]};
		end else begin
			asc2hex = 5'h00;
		end
	endfunction

	// characters allowed inside a frame body
	function automatic logic is_code_char(input logic [7:0] c);
		logic [4:0] h;
		h = asc2hex(c);
		is_code_char = h[4] || c == CH_UH || c == CH_UP ||
			c == CH_LB;
	endfunction

	// station address 1..32 as two decimal characters
	function automatic logic [15:0] addr_chars(input logic [5:0] a);
		logic [3:0] tens;
		logic [5:0] ones;
		tens = (a >= 6'd30) ? 4'd3 : (a >= 6'd20) ? 4'd2 :
			(a >= 6'd10) ? 4'd1 : 4'd0;
		ones = a - {2'b00, tens} * 6'd10;  // product kept six bits wide
		addr_chars = {hex2asc(tens), hex2asc(ones[3:0])};
	endfunction

	// byte number idx of the reply frame
	function automatic logic [7:0] reply_byte(input logic [3:0] idx,
		input logic nak, input logic [7:0] code, input logic [15:0] ac);
		logic [7:0] bcc;
		logic [7:0] e1;
		logic [7:0] e0;
		e1 = hex2asc(code[7:4]);
		e0 = hex2asc(code[3:0]);
		if (nak) begin
			bcc = ac[15:8] ^ ac[7:0] ^ CH_NAK ^ e1 ^ e0;
		end else begin
			bcc = ac[15:8] ^ ac[7:0] ^ CH_ACK;
		end
		case (idx)
			4'd0: reply_byte = CH_STX;
			4'd1: reply_byte = ac[15:8];
			4'd2: reply_byte = ac[7:0];
			4'd3: reply_byte = nak ? CH_NAK : CH_ACK;
			4'd4: reply_byte = nak ? e1 : hex2asc(bcc[7:4]);
			4'd5: reply_byte = nak ? e0 : hex2asc(bcc[3:0]);
			4'd6: reply_byte = nak ? hex2asc(bcc[7:4]) : CH_CR;
			4'd7: reply_byte = nak ? hex2asc(bcc[3:0]) : CH_CR;
			default: reply_byte = CH_CR;
		endcase
	endfunction

	// ************************************************************
	// declarations
	// ************************************************************
	arf_state_t state_r;
	arf_state_t state_nxt;
	logic [5:0] station_r;
	logic [2:0] err_action_r;
	logic [7:0] speed_sel_r;
	logic [13:0] timeout_lim_r;
	logic [13:0] wait_r;
	logic [19:0] char_cyc_r;
	logic boot_r;
	logic ph_valid_r;
	logic ph_write_r;
	logic [7:0] ph_addr_r;
	logic wr_en;
	logic rd_en;
	logic [31:0] rd_mux;
	logic [14:0] tick_cnt_r;
	logic tick;
	logic [4:0] len_r;
	logic [7:0] rx_xor_r;
	logic [7:0] prev1_r;
	logic [7:0] prev0_r;
	logic [15:0] node_r;
	logic [15:0] cmd_r;
	logic [7:0] err_r;
	logic [7:0] rx_err_code;
	logic [15:0] own_ac;
	logic [7:0] bcc_calc;
	logic [7:0] bcc_got;
	logic bcc_ok;
	logic is_bcast;
	logic is_mine;
	logic end_frame;
	logic [20:0] to_cnt_r;
	logic [20:0] to_lim;
	logic to_armed_r;
	logic to_hit;
	logic timeout_flag_r;
	logic query_ready_r;
	logic bcast_r;
	logic [7:0] last_err_r;
	logic reply_nak_r;
	logic [7:0] reply_code_r;
	logic reply_wr;
	logic auto_nak;
	logic [23:0] gap_cnt_r;
	logic [23:0] silent_cyc;
	logic [13:0] wait_cnt_r;
	logic gap_done;
	logic [3:0] idx_r;
	logic [3:0] last_idx;
	logic [4:0] hex_p1;
	logic [4:0] hex_p0;
	logic loop_sent_r;
	logic loop_done_r;
	logic loop_pass_r;

	// ************************************************************
	// ahb-lite slave, zero wait states, always okay
	// ************************************************************
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	// address phase capture
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ph_valid_r <= 1'b0;
			ph_write_r <= 1'b0;
			ph_addr_r <= 8'h00;
		end else if (hready) begin
			ph_valid_r <= hsel && htrans[1];
			ph_write_r <= hwrite;
			ph_addr_r <= {haddr[7:2], 2'b00};
		end
	end

	assign wr_en = ph_valid_r && ph_write_r;
	assign rd_en = hsel && htrans[1] && !hwrite && hready;
	assign reply_wr = wr_en && ph_addr_r == OFF_REPLY;

	// read data, unmapped offsets read zero
	always_comb begin
		case ({haddr[7:2], 2'b00})
			OFF_CTRL: rd_mux = {8'h00, speed_sel_r, 5'h00, err_action_r,
				2'b00, station_r};
			OFF_TIMEOUT: rd_mux = {18'h0, timeout_lim_r};
			OFF_WAIT: rd_mux = {18'h0, wait_r};
			OFF_CHARTIME: rd_mux = {12'h0, char_cyc_r};
			OFF_STATUS: rd_mux = {16'h0, last_err_r, 2'b00, to_armed_r,
				loop_pass_r, loop_done_r, timeout_flag_r, bcast_r,
				query_ready_r};
			OFF_QUERY: rd_mux = {node_r, cmd_r};
			default: rd_mux = 32'h0;
		endcase
	end

	// registered read data
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0;
		end else if (rd_en) begin
			hrdata <= rd_mux;
		end
	end

	// configuration registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			station_r <= RST_STATION;
			err_action_r <= RST_ERR_ACTION;
			speed_sel_r <= RST_SPEED_SEL;
			timeout_lim_r <= 14'h0;
			wait_r <= 14'h0;
			char_cyc_r <= 20'(CHAR_CYCLES);
			boot_r <= 1'b1;
		end else begin
			boot_r <= 1'b0;
			if (boot_r) begin
				speed_sel_r <= speed_select_strap;
			end else if (wr_en && ph_addr_r == OFF_CTRL) begin
				station_r <= hwdata[5:0];
				err_action_r <= hwdata[CTRL_ACT_LSB +: 3];
				speed_sel_r <= hwdata[CTRL_SPD_LSB +: 8];
			end
			if (wr_en && ph_addr_r == OFF_TIMEOUT) begin
				timeout_lim_r <= hwdata[13:0];
			end
			if (wr_en && ph_addr_r == OFF_WAIT) begin
				wait_r <= hwdata[13:0];
			end
			if (wr_en && ph_addr_r == OFF_CHARTIME) begin
				char_cyc_r <= hwdata[19:0];
			end
		end
	end

	// ************************************************************
	// 0.1 ms tick divider
	// ************************************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tick_cnt_r <= 15'h0;
		end else if (tick) begin
			tick_cnt_r <= 15'h0;
		end else begin
			tick_cnt_r <= tick_cnt_r + 15'h1;
		end
	end
	assign tick = tick_cnt_r == 15'(TICK_CYCLES - 1);

	// ************************************************************
	// query reception
	// ************************************************************
	always_comb begin
		if (rx_parity_err) begin
			rx_err_code = ERR_PARITY;
		end else if (rx_framing_err) begin
			rx_err_code = ERR_FRAMING;
		end else if (rx_overrun_err) begin
			rx_err_code = ERR_OVERRUN;
		end else if (len_r >= 5'(MAX_QUERY)) begin
			rx_err_code = ERR_BUF_OVR;
		end else if (rx_data != CH_CR && !is_code_char(rx_data)) begin
			rx_err_code = ERR_ASCII;
		end else begin
			rx_err_code = ERR_NONE;
		end
	end

	assign end_frame = state_r == ARF_RECV && rx_valid && rx_data == CH_CR;
	assign own_ac = addr_chars(station_r);
	// strip the two check characters from the running xor
	assign bcc_calc = rx_xor_r ^ prev1_r ^ prev0_r;
	assign hex_p1 = asc2hex(prev1_r);
	assign hex_p0 = asc2hex(prev0_r);
	assign bcc_got = {hex_p1[3:0], hex_p0[3:0]};
	assign bcc_ok = hex_p1[4] && hex_p0[4] &&
		bcc_got == bcc_calc;
	assign is_bcast = node_r == {CH_UF, CH_UF};
	assign is_mine = node_r == own_ac;
	assign auto_nak = err_r != ERR_NONE || len_r < 5'd4 || !bcc_ok;

	// frame assembly: length, running xor, fields, first error
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			len_r <= 5'h0;
			rx_xor_r <= 8'h0;
			prev1_r <= 8'h0;
			prev0_r <= 8'h0;
			node_r <= 16'h0;
			cmd_r <= 16'h0;
			err_r <= ERR_NONE;
		end else if (rx_valid && (state_r == ARF_IDLE ||
			state_r == ARF_RECV) && rx_data == CH_STX) begin
			len_r <= 5'h0;  // a new start in idle or receive restarts the frame
			rx_xor_r <= 8'h0;
			err_r <= ERR_NONE;
		end else if (rx_valid && state_r == ARF_RECV && !end_frame) begin
			if (len_r < 5'(MAX_QUERY)) begin
				len_r <= len_r + 5'h1;
			end
			rx_xor_r <= rx_xor_r ^ rx_data;
			prev1_r <= prev0_r;
			prev0_r <= rx_data;
			if (len_r == 5'd0) begin
				node_r[15:8] <= rx_data;
			end
			if (len_r == 5'd1) begin
				node_r[7:0] <= rx_data;
			end
			if (len_r == 5'd2) begin
				cmd_r[15:8] <= rx_data;
			end
			if (len_r == 5'd3) begin
				cmd_r[7:0] <= rx_data;
			end
			if (err_r == ERR_NONE) begin
				err_r <= rx_err_code;
			end
		end
	end

	// ************************************************************
	// reception timeout supervision
	// ************************************************************
	assign to_lim = 21'(timeout_lim_r * TIMEOUT_TICKS);
	assign to_hit = state_r == ARF_RECV && to_armed_r &&
		timeout_lim_r != 14'h0 && to_cnt_r >= to_lim;

	// timer runs only while a query is being received
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			to_armed_r <= 1'b0;
			to_cnt_r <= 21'h0;
		end else begin
			if (rx_valid && state_r == ARF_IDLE) begin
				to_armed_r <= 1'b1;
			end
			if (state_r != ARF_RECV) begin
				to_cnt_r <= 21'h0;
			end else if (tick) begin
				to_cnt_r <= to_cnt_r + 21'h1;
			end
		end
	end

	// sticky timeout flag and error action levels
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			timeout_flag_r <= 1'b0;
			comm_error_trip <= 1'b0;
			stop_decel_req <= 1'b0;
			stop_coast_req <= 1'b0;
		end else if (to_hit) begin
			timeout_flag_r <= 1'b1;  // set wins over clear
			comm_error_trip <= err_action_r == ACT_TRIP ||
				err_action_r == ACT_DECEL_TRIP;
			stop_decel_req <= err_action_r == ACT_DECEL_TRIP ||
				err_action_r == ACT_DECEL;
			stop_coast_req <= err_action_r == ACT_COAST;
		end else if (wr_en && ph_addr_r == OFF_STATUS &&
			hwdata[ST_TIMEOUT_BIT]) begin
			timeout_flag_r <= 1'b0;
			comm_error_trip <= 1'b0;
			stop_decel_req <= 1'b0;
			stop_coast_req <= 1'b0;
		end
	end

	// ************************************************************
	// sequencer
	// ************************************************************
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ARF_IDLE: begin
				if (boot_r && speed_select_strap == SPEED_LOOPBACK) begin
					state_nxt = ARF_LOOP;
				end else if (rx_valid && rx_data == CH_STX) begin
					state_nxt = ARF_RECV;
				end
			end
			ARF_RECV: begin
				if (to_hit) begin
					state_nxt = ARF_IDLE;
				end else if (end_frame) begin
					if (is_bcast || !is_mine) begin
						state_nxt = ARF_IDLE;
					end else if (auto_nak) begin
						state_nxt = ARF_GAP;
					end else begin
						state_nxt = ARF_DECIDE;
					end
				end
			end
			ARF_DECIDE: begin
				if (reply_wr) begin
					state_nxt = ARF_GAP;
				end
			end
			ARF_GAP: begin
				if (gap_done) begin
					state_nxt = ARF_SEND;
				end
			end
			ARF_SEND: begin
				if (tx_ready && idx_r == last_idx) begin
					state_nxt = ARF_IDLE;
				end
			end
			ARF_LOOP: state_nxt = ARF_LOOP;
			default: state_nxt = ARF_IDLE;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_r <= ARF_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// query notification and reply selection
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			query_ready_r <= 1'b0;
			bcast_r <= 1'b0;
			last_err_r <= ERR_NONE;
			reply_nak_r <= 1'b0;
			reply_code_r <= ERR_NONE;
		end else if (to_hit) begin
			last_err_r <= ERR_TIMEOUT;
		end else if (end_frame && (is_mine || is_bcast)) begin
			bcast_r <= is_bcast;
			query_ready_r <= !auto_nak;
			reply_nak_r <= 1'b1;
			if (err_r != ERR_NONE) begin
				reply_code_r <= err_r;
			end else if (len_r < 5'd4) begin
				reply_code_r <= ERR_PROTOCOL;
			end else begin
				reply_code_r <= ERR_CHECKSUM;
			end
			last_err_r <= err_r != ERR_NONE ? err_r :
				len_r < 5'd4 ? ERR_PROTOCOL :
				bcc_ok ? ERR_NONE : ERR_CHECKSUM;
		end else if (reply_wr && state_r == ARF_DECIDE) begin
			query_ready_r <= 1'b0;
			reply_nak_r <= hwdata[REPLY_NAK_BIT];
			reply_code_r <= hwdata[7:0];
		end
	end

	// ************************************************************
	// silent interval plus wait time before the reply
	// ************************************************************
	assign silent_cyc = 24'((char_cyc_r * 7 + 1) >> 1);
	assign gap_done = gap_cnt_r >= silent_cyc && wait_cnt_r >= wait_r;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			gap_cnt_r <= 24'h0;
			wait_cnt_r <= 14'h0;
		end else if (state_r != ARF_GAP) begin
			gap_cnt_r <= 24'h0;
			wait_cnt_r <= 14'h0;
		end else if (gap_cnt_r < silent_cyc) begin
			gap_cnt_r <= gap_cnt_r + 24'h1;
		end else if (tick && wait_cnt_r < wait_r) begin
			wait_cnt_r <= wait_cnt_r + 14'h1;
		end
	end

	// ************************************************************
	// reply transmission and loopback test
	// ************************************************************
	assign last_idx = reply_nak_r ? 4'd8 : 4'd6;
	assign tx_valid = state_r == ARF_SEND ||
		(state_r == ARF_LOOP && !loop_sent_r);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			idx_r <= 4'h0;
			tx_data <= 8'h00;
		end else if (state_nxt == ARF_LOOP) begin
			tx_data <= LOOP_PATTERN;  // ready as tx_valid rises
		end else if (state_r == ARF_GAP) begin
			idx_r <= 4'h0;
			tx_data <= CH_STX;
		end else if (state_r == ARF_SEND && tx_ready) begin
			idx_r <= idx_r + 4'h1;
			tx_data <= reply_byte(idx_r + 4'h1, reply_nak_r, reply_code_r,
				own_ac);
		end
	end

	// loopback: send one pattern, compare the echo
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			loop_sent_r <= 1'b0;
			loop_done_r <= 1'b0;
			loop_pass_r <= 1'b0;
		end else if (state_r == ARF_LOOP) begin
			if (tx_valid && tx_ready) begin
				loop_sent_r <= 1'b1;
			end
			if (loop_sent_r && !loop_done_r && rx_valid) begin
				loop_done_r <= 1'b1;
				loop_pass_r <= rx_data == LOOP_PATTERN && rx_err_code !=
					ERR_PARITY && !rx_framing_err && !rx_overrun_err;
			end
		end
	end
endmodule

// ---- testbench/arf_top_monitor.sv ----
// assertions watching the reply framer ports
`timescale 1ns/10ps
// ****
// checker
// ****
module arf_monitor
	import arf_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic rx_valid,
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	input wire logic tx_ready,
	input wire logic stop_decel_req,
	input wire logic stop_coast_req
);
	logic [3:0] idx_r;
	logic [3:0] bpos;
	logic [7:0] x_r;
	logic nak_r;
	logic seen_r;
	logic take;
	function automatic logic [7:0] hx(input logic [3:0] v);
		return v > 4'h9 ? CH_HEX_AF + v : CH_ZERO + v;
	endfunction
	// a byte leaves, and where the check characters sit
	assign take = tx_valid && tx_ready;
	assign bpos = nak_r ? 4'h6 : 4'h4;
	// position, kind and running check of the reply in flight
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			idx_r <= 4'h0;
			nak_r <= 1'b0;
			x_r <= 8'h00;
		end else if (take) begin
			if (tx_data == CH_CR || tx_data == LOOP_PATTERN)
				idx_r <= 4'h0;
			else
				idx_r <= idx_r + 4'h1;
			if (idx_r == 4'h3)
				nak_r <= tx_data == CH_NAK;
			if (idx_r == 4'h0)
				x_r <= 8'h00;
			else if (idx_r < bpos)
				x_r <= x_r ^ tx_data;
		end
	end
	// the master has spoken since reset
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			seen_r <= 1'b0;
		else if (rx_valid)
			seen_r <= 1'b1;
	end
	default clocking @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	sequence cr_taken;
		take && tx_data == CH_CR;
	endsequence
	sequence stalled;
		tx_valid && !tx_ready;
	endsequence
	frame_start_a:
		assert property (tx_valid && idx_r == 4'h0 |->
			tx_data == CH_STX || tx_data == LOOP_PATTERN)
		else $error("reply opens badly");
	ctrl_char_a:
		assert property (tx_valid && idx_r == 4'h3 |->
			tx_data == CH_ACK || tx_data == CH_NAK)
		else $error("bad control char");
	check_hi_a:
		assert property (tx_valid && idx_r == bpos |->
			tx_data == hx(x_r[7:4]))
		else $error("bad check high char");
	check_lo_a:
		assert property (tx_valid && idx_r == bpos + 4'h1 |->
			tx_data == hx(x_r[3:0]))
		else $error("bad check low char");
	cr_place_a:
		assert property (tx_valid && idx_r == bpos + 4'h2 |->
			tx_data == CH_CR)
		else $error("reply end misplaced");
	frame_end_a:
		assert property (cr_taken |=> !tx_valid)
		else $error("sending after end");
	hold_byte_a:
		assert property (stalled |=> tx_valid && $stable(tx_data))
		else $error("byte dropped while stalled");
	reply_only_a:
		assert property (tx_valid |-> seen_r || tx_data == LOOP_PATTERN)
		else $error("unsolicited send");
	act_excl_a:
		assert property (!(stop_decel_req && stop_coast_req))
		else $error("two stop kinds");
endmodule
bind arf_top arf_monitor arf_monitor_i (.hclk(hclk), .hresetn(hresetn),
	.rx_valid(rx_valid), .tx_valid(tx_valid), .tx_data(tx_data),
	.tx_ready(tx_ready), .stop_decel_req(stop_decel_req),
	.stop_coast_req(stop_coast_req));

// ---- testbench/arf_host.sv ----
// host master model sending queries and taking replies
`timescale 1ns/10ps
// ****
// serial master
// ****
module arf_host
	import arf_pkg::*;
(
	input wire logic hclk,
	output logic rx_valid,
	output logic [7:0] rx_data,
	output logic tx_ready
);
	logic slow = 1'b0;
	logic [1:0] cnt_r = 2'h0;
	// quiet line at start
	initial begin
		rx_valid = 1'b0;
		rx_data = 8'h00;
		tx_ready = 1'b0;
	end
	function automatic logic [7:0] hexc(input logic [3:0] v);
		return v > 4'h9 ? CH_HEX_AF + v : CH_ZERO + v;
	endfunction
	// takes a reply byte every fourth cycle when slow
	always @(posedge hclk) begin
		cnt_r <= cnt_r + 2'h1;
		tx_ready <= !slow || cnt_r == 2'h3;
	end
	// one byte, then the line shows junk
	task automatic send_byte(input logic [7:0] b);
		rx_valid <= 1'b1;
		rx_data <= b;
		@(posedge hclk);
		rx_valid <= 1'b0;
		rx_data <= ~b;
		@(posedge hclk);
	endtask
	// silence, then the first cut bytes of a query
	task automatic send_query(input logic [7:0] n1, input logic [7:0] n0,
		input logic [7:0] c0, input logic bad, input int cut);
		logic [7:0] f[8];
		logic [7:0] k;
		k = n1 ^ n0 ^ CH_ZERO ^ c0 ^ {7'h00, bad};
		f = '{CH_STX, n1, n0, CH_ZERO, c0, hexc(k[7:4]),
			hexc(k[3:0]), CH_CR};
		repeat (20) @(posedge hclk);
		for (int i = 0; i < cut; i++)
			send_byte(f[i]);
	endtask
endmodule

// ---- testbench/arf_top_bench.sv ----
// self-checking bench for the ascii reply framer
`timescale 1ns/10ps
`define CHK(nm, e, g) begin \
	checks_done++; \
	if ((g) !== (e)) begin \
		err_total++; \
		$display("ERROR %s exp %h got %h", nm, e, g); \
	end \
end
// ****
// bench
// ****
module arf_top_bench
	import arf_pkg::*;
;
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic [7:0] haddr = 8'h00, strap = 8'h04, rx_data, tx_data, tx_e;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0, hrdata, lfsr = 32'h15D7;
	logic hreadyout, hresp, rx_valid, tx_valid, tx_ready, rd_dp = 1'b0;
	logic trip, decel, coast;
	logic [1:0] rx_e = 2'h0;
	logic [7:0] tx_q[$];
	logic [63:0] rd_q[$];
	logic [63:0] rd_e;
	int err_total = 0, checks_done = 0, cyc = 0, n;
	always #2.5 hclk = ~hclk;
	arf_top #(.TICK_CYCLES(2), .CHAR_CYCLES(4)) arf_top_i (.hclk(hclk),
		.hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .speed_select_strap(strap), .rx_valid(rx_valid),
		.rx_data(rx_data), .rx_parity_err(rx_e[0]),
		.rx_framing_err(rx_e[1]),
		.rx_overrun_err(1'b0), .tx_valid(tx_valid), .tx_data(tx_data),
		.tx_ready(tx_ready), .comm_error_trip(trip),
		.stop_decel_req(decel), .stop_coast_req(coast));
	arf_host arf_host_i (.hclk(hclk), .rx_valid(rx_valid),
		.rx_data(rx_data), .tx_ready(tx_ready));
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// one single word transfer; a read notes its expected value
	task automatic bus(input logic wr, input logic [7:0] a,
		input logic [31:0] d, input logic [31:0] m);
		if (!wr)
			rd_q.push_back({m, d});
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= wr;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
	endtask
	// notes the bytes of the reply to station 01
	task automatic exp_reply(input logic nak, input logic [7:0] c);
		logic [7:0] k;
		k = CH_ZERO ^ 8'h31 ^ (nak ? CH_NAK : CH_ACK);
		tx_q.push_back(CH_STX);
		tx_q.push_back(CH_ZERO);
		tx_q.push_back(8'h31);
		tx_q.push_back(nak ? CH_NAK : CH_ACK);
		if (nak) begin
			tx_q.push_back(arf_host_i.hexc(c[7:4]));
			tx_q.push_back(arf_host_i.hexc(c[3:0]));
			k = k ^ arf_host_i.hexc(c[7:4]) ^ arf_host_i.hexc(c[3:0]);
		end
		tx_q.push_back(arf_host_i.hexc(k[7:4]));
		tx_q.push_back(arf_host_i.hexc(k[3:0]));
		tx_q.push_back(CH_CR);
	endtask
	// clean or corrupted query to station 01, random command digit
	task automatic query(input logic bad);
		lfsr = lfsr_next(lfsr);
		arf_host_i.send_query(CH_ZERO, 8'h31, CH_ZERO + {5'h00, lfsr[2:0]},
			bad, 8);
	endtask
	task automatic drain(input string s);
		for (n = 0; n < 600 && (tx_q.size() != 0 || tx_valid); n++)
			@(posedge hclk);
		`CHK("left", 0, tx_q.size())
		$display("test %s done", s);
	endtask
	task automatic print_verdict;
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// compares sent bytes and read data with the oldest notes
	always @(posedge hclk) begin
		if (rd_dp) begin
			rd_e = rd_q.pop_front();
			`CHK("hrdata", rd_e[31:0], hrdata & rd_e[63:32])
			`CHK("hresp", 2'b01, {hresp, hreadyout})
		end
		rd_dp <= hsel && htrans[1] && !hwrite && hreadyout;
		if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
			tx_e = tx_q.size() ? tx_q.pop_front() : 8'hXX;
			`CHK("tx_data", tx_e, tx_data)
		end
	end
	// cuts a hung run short
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			print_verdict;
		end
	end
	initial begin
		logic [7:0] codes[11];
		logic [2:0] acts[5];
		codes = '{ERR_PARITY, ERR_CHECKSUM, ERR_FRAMING, ERR_OVERRUN,
			ERR_PROTOCOL, ERR_ASCII, ERR_BUF_OVR, ERR_TIMEOUT, ERR_UNK_CMD,
			ERR_EXEC_DIS, ERR_PARAM};
		acts = '{3'h4, 3'h6, 3'h0, 3'h1, 3'h2};
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		bus(0, OFF_CTRL, 32'h0004_0201, 32'h00FF_073F);
		bus(0, OFF_TIMEOUT, 0, 32'h3FFF);
		bus(0, 8'h1C, 0, 32'hFFFF_FFFF);
		query(0);
		bus(0, OFF_STATUS, 1, 1);
		exp_reply(0, 0);
		bus(1, OFF_REPLY, 0, 0);
		drain("ack");
		arf_host_i.slow <= 1'b1;
		query(1);
		exp_reply(1, ERR_CHECKSUM);
		drain("bad check");
		arf_host_i.slow <= 1'b0;
		for (int e = 1; e < 3; e++) begin
			rx_e <= 2'(e);
			query(0);
			rx_e <= 2'h0;
			exp_reply(1, e == 1 ? ERR_PARITY : ERR_FRAMING);
			drain("rx fault");
		end
		foreach (codes[i]) begin
			query(0);
			exp_reply(1, codes[i]);
			bus(1, OFF_REPLY, {23'h0, 1'b1, codes[i]}, 0);
			drain("nak code");
		end
		bus(1, OFF_WAIT, 3, 0);
		query(0);
		exp_reply(0, 0);
		bus(1, OFF_REPLY, 0, 0);
		for (n = 0; n < 100 && tx_valid !== 1'b1; n++)
			@(posedge hclk);
		`CHK("wait", 1'b1, n >= 20 && n <= 24)
		drain("wait");
		bus(1, OFF_WAIT, 0, 0);
		arf_host_i.send_query(CH_UF, CH_UF, 8'h31, 0, 8);
		bus(0, OFF_STATUS, 3, 3);
		bus(1, OFF_REPLY, 0, 0);
		repeat (80) @(posedge hclk);
		$display("test broadcast done");
		bus(1, OFF_TIMEOUT, 1, 0);
		foreach (acts[a]) begin
			bus(1, OFF_CTRL, {8'h00, 8'h04, 5'h00, a[2:0], 8'h01}, 0);
			arf_host_i.send_query(CH_ZERO, 8'h31, CH_ZERO, 0, 3);
			repeat (300) @(posedge hclk);
			`CHK("actions", acts[a], {trip, decel, coast})
			bus(0, OFF_STATUS, 32'h0804, 32'hFF04);
			bus(1, OFF_STATUS, 4, 0);
			@(posedge hclk);
			`CHK("cleared", 3'h0, {trip, decel, coast})
		end
		bus(1, OFF_TIMEOUT, 0, 0);
		query(0);
		exp_reply(0, 0);
		bus(1, OFF_REPLY, 0, 0);
		drain("timeout");
		hresetn <= 1'b0;
		strap <= SPEED_LOOPBACK;
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		tx_q.push_back(LOOP_PATTERN);
		drain("loop send");
		arf_host_i.send_byte(LOOP_PATTERN);
		repeat (5) @(posedge hclk);
		bus(0, OFF_STATUS, 32'h18, 32'h18);
		bus(0, OFF_CTRL, 32'h0002_0000, 32'h00FF_0000);
		print_verdict;
	end
endmodule
